// ### core/ifb_core.sv
// integer function units scanned round-robin, configured over an APB slave
//
// Decided for this implementation: the register offsets and the APB register port.
`default_nettype none

module ifb_core
  import ifb_pkg::*;
#(
  parameter int MS_CYCLES_P = MS_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [NUM_UNITS-1:0] errorCoil
);

  localparam logic [15:0] MS_LAST = 16'(MS_CYCLES_P - 1);
  localparam logic [6:0] IDX_LAST = 7'(NUM_UNITS - 1);

  typedef struct packed {
    logic [NUM_PARAM-1:0][16:0] param;
    logic [NUM_UNITS-1:0][4:0] ctrl;
    logic [NUM_UNITS-1:0][15:0] result;
    logic [NUM_UNITS-1:0] errCoil;
    logic [6:0] idx;
    logic [15:0] msCnt;
    logic tickPend;
    logic stepScan;
    logic [NUM_PID-1:0][31:0] pidPrevErr;
    logic [NUM_PID-1:0][15:0] pidPv1;
    logic [NUM_PID-1:0][15:0] pidPv2;
    logic [NUM_PID-1:0][47:0] pidAcc;
    logic [NUM_PID-1:0][15:0] pidCnt;
    ifb_phase_t [NUM_AR-1:0] arPhase;
    logic [NUM_AR-1:0][15:0] arLevel;
    logic [NUM_AR-1:0][6:0] arHold;
    logic [NUM_AR-1:0] arHaltPrev;
    logic [31:0] rdata;
  } ifb_state_t;

  ifb_state_t state_ff;
  ifb_state_t nxt_state;

  // an operand word is a constant or, with the reference bit, another unit's result
  function automatic logic [15:0] resolve(input logic [16:0] w, input logic [NUM_UNITS-1:0][15:0] res);
    if (!w[PARAM_REF_BIT]) begin
      return w[15:0];
    end
    if (w[6:0] < 7'(NUM_UNITS)) begin
      return res[w[6:0]];
    end
    return 16'h0000;
  endfunction : resolve

  // the scan index range decides the unit kind
  function automatic ifb_kind_t unitKind(input logic [6:0] i);
    if (i < 7'(BASE_MD)) begin
      return K_AS;
    end
    if (i < 7'(BASE_PID)) begin
      return K_MD;
    end
    if (i < 7'(BASE_MX)) begin
      return K_PID;
    end
    if (i < 7'(BASE_AR)) begin
      return K_MX;
    end
    return K_AR;
  endfunction : unitKind

  // ==========================================================================
  // operand fetch for the unit being visited
  logic [SLOTS-1:0][15:0] op;
  ifb_kind_t kind;
  logic [4:0] ctl;
  logic en;
  logic tgt;
  logic [3:0] pidI;
  logic [3:0] rampI;

  for (genvar k = 0; k < SLOTS; k++) begin : g_fetch
    assign op[k] = resolve(state_ff.param[{state_ff.idx, 3'(k)}], state_ff.result);
  end
  assign kind = unitKind(state_ff.idx);
  assign ctl = state_ff.ctrl[state_ff.idx];
  assign en = ctl[CTRL_EN];
  assign tgt = ctl[CTRL_TGT];
  assign pidI = 4'(state_ff.idx - 7'(BASE_PID));
  assign rampI = 4'(state_ff.idx - 7'(BASE_AR));

  // ==========================================================================
  // arithmetic and ramp datapaths
  logic [15:0] aluRes;
  logic aluOvf;
  ifb_phase_t rampPhase;
  logic [15:0] rampLevel;
  logic [6:0] rampHold;
  logic [15:0] rampRes;
  logic rampErr;

  ifb_arith u_arith (
    .kind(kind),
    .v1(op[SLOT_V1]),
    .v2(op[SLOT_V2]),
    .v3(op[SLOT_V3]),
    .v4(op[SLOT_V4]),
    .selHigh(ctl[CTRL_SELH]),
    .selLow(ctl[CTRL_SELL]),
    .result(aluRes),
    .overflow(aluOvf)
  );

  ifb_ramp u_ramp (
    .enable(en),
    .haltReq(ctl[CTRL_HALT]),
    .haltPrev(state_ff.arHaltPrev[rampI]),
    .step(state_ff.stepScan),
    .levelChoice(ctl[CTRL_SELH]),
    .level1(op[SLOT_L1]),
    .level2(op[SLOT_L2]),
    .ceilingLevel(op[SLOT_CEIL]),
    .rampBaseLevel(op[SLOT_BASE]),
    .offset(op[SLOT_OFS]),
    .rate(op[SLOT_RATE]),
    .scale(op[SLOT_SCALE]),
    .phaseIn(state_ff.arPhase[rampI]),
    .levelIn(state_ff.arLevel[rampI]),
    .holdIn(state_ff.arHold[rampI]),
    .phaseOut(rampPhase),
    .levelOut(rampLevel),
    .holdOut(rampHold),
    .result(rampRes),
    .error(rampErr)
  );

  // ==========================================================================
  // PID terms; 48-bit intermediates so no product wraps
  logic signed [47:0] ev;
  logic signed [47:0] dE;
  logic signed [47:0] iTerm;
  logic signed [47:0] dTerm;
  logic signed [47:0] accNew;
  logic pidZero;

  assign ev = 48'(signed'(op[SLOT_SP])) - 48'(signed'(op[SLOT_PV]));
  assign dE = ev - 48'(signed'(state_ff.pidPrevErr[pidI]));
  // a zero integral time disables the integral term instead of dividing by zero
  assign iTerm = (op[SLOT_TI] == 16'h0000) ? 48'sd0 :
      (48'(signed'(op[SLOT_TS])) * ev) / 48'(signed'(op[SLOT_TI]));
  assign dTerm = (op[SLOT_TS] == 16'h0000) ? 48'sd0 :
      (48'(signed'(op[SLOT_TD])) * (48'sd2 * 48'(signed'(state_ff.pidPv1[pidI]))
      - 48'(signed'(op[SLOT_PV])) - 48'(signed'(state_ff.pidPv2[pidI]))))
      / 48'(signed'(op[SLOT_TS]));
  assign accNew = signed'(state_ff.pidAcc[pidI]) + 48'(signed'(op[SLOT_KP])) * (dE + iTerm + dTerm);
  assign pidZero = (op[SLOT_TS] == 16'h0000) || (op[SLOT_KP] == 16'h0000);

  // ==========================================================================
  // APB decode: param words, per-unit control, per-unit status
  logic [3:0] region;
  logic [9:0] wordIdx;
  logic [6:0] unitIdx;
  logic paramHit;
  logic ctrlHit;
  logic statHit;
  logic apbErr;
  logic apbWrite;
  logic [31:0] readMux;

  assign region = paddr[15:12];
  assign wordIdx = paddr[11:2];
  assign unitIdx = paddr[8:2];
  assign paramHit = (region == REGION_PARAM) && (wordIdx < 10'(NUM_PARAM));
  assign ctrlHit = (region == REGION_CTRL) && (paddr[11:9] == 3'h0) && (unitIdx < 7'(NUM_UNITS));
  assign statHit = (region == REGION_STAT) && (paddr[11:9] == 3'h0) && (unitIdx < 7'(NUM_UNITS));
  // status is read-only, so a write there is answered as an error
  assign apbErr = !(paramHit || ctrlHit || statHit) || (pwrite && statHit);
  assign apbWrite = psel && penable && pwrite && !apbErr;
  assign readMux = paramHit ? {15'h0000, state_ff.param[wordIdx]} :
      ctrlHit ? {27'h0000000, state_ff.ctrl[unitIdx]} :
      statHit ? {15'h0000, state_ff.errCoil[unitIdx], state_ff.result[unitIdx]} : 32'h00000000;
  assign pready = 1'b1;
  assign pslverr = psel && penable && apbErr;
  assign prdata = state_ff.rdata;
  assign errorCoil = state_ff.errCoil;

  // ==========================================================================
  // next state: ms divider, scan step, unit update, register writes
  always_comb begin
    logic tick;
    logic [15:0] unitRes;
    logic unitErr;
    tick = 1'b0;
    unitRes = 16'h0000;
    unitErr = 1'b0;
    nxt_state = state_ff;
    if (state_ff.msCnt == MS_LAST) begin
      nxt_state.msCnt = 16'h0000;
      tick = 1'b1;
    end else begin
      nxt_state.msCnt = state_ff.msCnt + 16'h0001;
    end
    // a tick is latched and applied to one whole scan, so each unit sees it once
    if (state_ff.idx == 7'h00) begin
      nxt_state.stepScan = state_ff.tickPend || tick;
      nxt_state.tickPend = 1'b0;
    end else begin
      nxt_state.tickPend = state_ff.tickPend || tick;
    end
    nxt_state.idx = (state_ff.idx == IDX_LAST) ? 7'h00 : state_ff.idx + 7'h01;
    case (kind)
      K_AS, K_MD: begin
        unitRes = aluRes;
        unitErr = aluOvf;
      end
      K_MX: unitRes = en ? aluRes : 16'h0000;
      K_PID: begin
        unitErr = pidZero;
        unitRes = ifb_sat16(signed'(state_ff.pidAcc[pidI]));
        if (!en) begin
          nxt_state.pidPrevErr[pidI] = 32'h00000000;
          nxt_state.pidPv1[pidI] = 16'h0000;
          nxt_state.pidPv2[pidI] = 16'h0000;
          nxt_state.pidAcc[pidI] = 48'h000000000000;
          nxt_state.pidCnt[pidI] = 16'h0000;
          unitRes = 16'h0000;
        end else if (state_ff.stepScan) begin
          // one sample every sample_period milliseconds
          if (state_ff.pidCnt[pidI] + 16'h0001 >= op[SLOT_TS]) begin
            nxt_state.pidCnt[pidI] = 16'h0000;
            nxt_state.pidPrevErr[pidI] = ev[31:0];
            nxt_state.pidPv2[pidI] = state_ff.pidPv1[pidI];
            nxt_state.pidPv1[pidI] = op[SLOT_PV];
            nxt_state.pidAcc[pidI] = accNew;
            unitRes = ifb_sat16(accNew);
          end else begin
            nxt_state.pidCnt[pidI] = state_ff.pidCnt[pidI] + 16'h0001;
          end
        end
      end
      K_AR: begin
        nxt_state.arPhase[rampI] = rampPhase;
        nxt_state.arLevel[rampI] = rampLevel;
        nxt_state.arHold[rampI] = rampHold;
        nxt_state.arHaltPrev[rampI] = en && ctl[CTRL_HALT];
        unitRes = rampRes;
        unitErr = rampErr;
      end
      default: unitRes = 16'h0000;
    endcase
    nxt_state.result[state_ff.idx] = unitRes;
    // the coil only shows an error while enabled and wired to a target
    nxt_state.errCoil[state_ff.idx] = en && tgt && unitErr;
    if (apbWrite && paramHit) begin
      nxt_state.param[wordIdx] = pwdata[16:0];
    end
    if (apbWrite && ctrlHit) begin
      nxt_state.ctrl[unitIdx] = pwdata[4:0];
    end
    // read data is captured in the setup cycle and shown in the access phase
    if (psel && !penable) begin
      nxt_state.rdata = readMux;
    end
  end

  // state register
  always_ff @(posedge clock) begin
    if (rst) begin
      state_ff <= '0;
      // element by element, so each enum element takes a legal code
      for (int r = 0; r < NUM_AR; r++) begin
        state_ff.arPhase[r] <= R_IDLE;
      end
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ==========================================================================
  // checks on the visited unit, one cycle after its visit
  logic [15:0] asExpect;
  logic [15:0] mdExpect;
  assign asExpect = 16'(op[SLOT_V1] + op[SLOT_V2] - op[SLOT_V3]);
  assign mdExpect = 16'((32'(signed'(op[SLOT_V1])) * 32'(signed'(op[SLOT_V2])))
      / 32'(signed'(op[SLOT_V3])));

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  a_as_result: assert property ((kind == K_AS) |=>
      state_ff.result[$past(state_ff.idx)] == $past(asExpect))
    else $error("add-subtract result wrong");
  a_md_result: assert property ((kind == K_MD && op[SLOT_V3] != 16'h0000) |=>
      state_ff.result[$past(state_ff.idx)] == $past(mdExpect))
    else $error("multiply-divide result wrong");
  a_ovf_coil: assert property ((kind == K_AS && en && tgt && asExpect[15] !=
      (signed'(op[SLOT_V1]) + signed'(op[SLOT_V2]) - signed'(op[SLOT_V3]) < 0)) |=>
      state_ff.errCoil[$past(state_ff.idx)])
    else $error("overflow did not raise coil");
  a_no_target: assert property (!tgt |=> !state_ff.errCoil[$past(state_ff.idx)])
    else $error("coil raised without target");
  a_disable_clear: assert property (!en |=> !state_ff.errCoil[$past(state_ff.idx)])
    else $error("coil not cleared while disabled");
  a_mx_zero: assert property ((kind == K_MX && !en) |=>
      state_ff.result[$past(state_ff.idx)] == 16'h0000)
    else $error("disabled selector not zero");
  a_mx_select: assert property ((kind == K_MX && en && ctl[CTRL_SELH] && !ctl[CTRL_SELL]) |=>
      state_ff.result[$past(state_ff.idx)] == $past(op[SLOT_V3]))
    else $error("selector picked wrong operand");
  a_pid_zero: assert property ((kind == K_PID && en && tgt && op[SLOT_KP] == 16'h0000) |=>
      state_ff.errCoil[$past(state_ff.idx)])
    else $error("zero gain not flagged");
  a_md_divzero: assert property ((kind == K_MD && en && tgt && op[SLOT_V3] == 16'h0000) |=>
      state_ff.errCoil[$past(state_ff.idx)])
    else $error("zero divisor not flagged");
  a_ar_scale: assert property ((kind == K_AR && en && tgt && op[SLOT_SCALE] == 16'h0000) |=>
      state_ff.errCoil[$past(state_ff.idx)])
    else $error("zero scale not flagged");

endmodule : ifb_core

`default_nettype wire

// ### core/ifb_pkg.sv
// constants, types and helpers shared by the integer function blocks
// ============================================================================
// Notes on behaviour
// - add-subtract gives V1 plus V2 minus V3
// - multiply-divide gives V1 times V2 over V3
// - overflow drives the unit's error coil high
// - no-target units never raise their coil
// - coil clears on valid result or disable
// - 31 add-subtract and 31 multiply-divide units
// - 15 PID, selector and ramp units each
// - disabled selector outputs zero
// - selector picks V1..V4, high bit first
// - PID error when period or gain zero
// - PID accumulates gain times three-term sum
// - ramp holds base plus offset 100ms, then slews
// - level choice picks first or second level
// - target above ceiling is replaced by ceiling
// - halt edge: slew back to start level, hold 100ms, drop
// - ramp result is level minus offset, scaled
// - ramp error coil when scale divisor zero
`default_nettype none

package ifb_pkg;

  // ==========================================================================
  // unit population and scan order
  localparam int NUM_AS = 31;
  localparam int NUM_MD = 31;
  localparam int NUM_PID = 15;
  localparam int NUM_MX = 15;
  localparam int NUM_AR = 15;
  localparam int NUM_UNITS = NUM_AS + NUM_MD + NUM_PID + NUM_MX + NUM_AR;
  localparam int BASE_MD = NUM_AS;
  localparam int BASE_PID = BASE_MD + NUM_MD;
  localparam int BASE_MX = BASE_PID + NUM_PID;
  localparam int BASE_AR = BASE_MX + NUM_MX;
  localparam int SLOTS = 8;
  localparam int NUM_PARAM = NUM_UNITS * SLOTS;

  // ==========================================================================
  // register map: byte address bits [15:12] pick the region
  localparam logic [3:0] REGION_PARAM = 4'h0;
  localparam logic [3:0] REGION_CTRL = 4'h1;
  localparam logic [3:0] REGION_STAT = 4'h2;
  localparam int PARAM_REF_BIT = 16;
  localparam logic [16:0] PARAM_RESET = 17'h00000;
  localparam int CTRL_EN = 0;
  localparam int CTRL_TGT = 1;
  localparam int CTRL_SELH = 2;
  localparam int CTRL_SELL = 3;
  localparam int CTRL_HALT = 4;
  localparam logic [4:0] CTRL_RESET = 5'h00;
  localparam int STAT_ERR_BIT = 16;

  // ==========================================================================
  // operand slots per unit kind
  localparam int SLOT_V1 = 0;
  localparam int SLOT_V2 = 1;
  localparam int SLOT_V3 = 2;
  localparam int SLOT_V4 = 3;
  localparam int SLOT_SP = 0;
  localparam int SLOT_PV = 1;
  localparam int SLOT_TS = 2;
  localparam int SLOT_KP = 3;
  localparam int SLOT_TI = 4;
  localparam int SLOT_TD = 5;
  localparam int SLOT_L1 = 0;
  localparam int SLOT_L2 = 1;
  localparam int SLOT_CEIL = 2;
  localparam int SLOT_BASE = 3;
  localparam int SLOT_OFS = 4;
  localparam int SLOT_RATE = 5;
  localparam int SLOT_SCALE = 6;

  // ==========================================================================
  // timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int MS_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int HOLD_TIME_MS = 100;
  localparam logic [6:0] HOLD_TICKS = 7'(HOLD_TIME_MS);

  typedef enum logic [4:0] {
    K_AS = 5'h01,
    K_MD = 5'h02,
    K_PID = 5'h04,
    K_MX = 5'h08,
    K_AR = 5'h10
  } ifb_kind_t;

  typedef enum logic [5:0] {
    R_IDLE = 6'h01,
    R_HOLD = 6'h02,
    R_RUN = 6'h04,
    R_DOWN = 6'h08,
    R_LAST = 6'h10,
    R_DONE = 6'h20
  } ifb_phase_t;

  // clamp a wide signed value into the 16-bit result range
  function automatic logic [15:0] ifb_sat16(input logic signed [47:0] v);
    if (v > 48'sd32767) begin
      return 16'h7FFF;
    end
    if (v < -48'sd32768) begin
      return 16'h8000;
    end
    return v[15:0];
  endfunction : ifb_sat16

endpackage : ifb_pkg

`default_nettype wire

// ### core/ifb_arith.sv
// add-subtract, multiply-divide and selector datapath for one unit visit
`default_nettype none

module ifb_arith
  import ifb_pkg::*;
(
  input wire ifb_kind_t kind,
  input wire logic [15:0] v1,
  input wire logic [15:0] v2,
  input wire logic [15:0] v3,
  input wire logic [15:0] v4,
  input wire logic selHigh,
  input wire logic selLow,
  output logic [15:0] result,
  output logic overflow
);

  logic signed [17:0] sum;
  logic signed [31:0] prod;
  logic signed [31:0] quot;

  // widen before combining so the range check sees the true value
  assign sum = 18'(signed'(v1)) + 18'(signed'(v2)) - 18'(signed'(v3));
  assign prod = 32'(signed'(v1)) * 32'(signed'(v2));
  assign quot = (v3 == 16'h0000) ? 32'sd0 : prod / 32'(signed'(v3));

  // ==========================================================================
  // result select per unit kind
  always_comb begin
    result = 16'h0000;
    overflow = 1'b0;
    case (kind)
      K_AS: begin
        result = sum[15:0];
        overflow = (sum > 18'sd32767) || (sum < -18'sd32768);
      end
      K_MD: begin
        result = quot[15:0];
        overflow = (v3 == 16'h0000) || (quot > 32'sd32767) || (quot < -32'sd32768);
      end
      K_MX: begin
        case ({selHigh, selLow})
          2'b00: result = v1;
          2'b01: result = v2;
          2'b10: result = v3;
          default: result = v4;
        endcase
      end
      default: result = 16'h0000;
    endcase
  end

endmodule : ifb_arith

`default_nettype wire

// ### core/ifb_ramp.sv
// next-state logic of one analog ramp unit, evaluated on its scan visit
`default_nettype none

module ifb_ramp
  import ifb_pkg::*;
(
  input wire logic enable,
  input wire logic haltReq,
  input wire logic haltPrev,
  input wire logic step,
  input wire logic levelChoice,
  input wire logic [15:0] level1,
  input wire logic [15:0] level2,
  input wire logic [15:0] ceilingLevel,
  input wire logic [15:0] rampBaseLevel,
  input wire logic [15:0] offset,
  input wire logic [15:0] rate,
  input wire logic [15:0] scale,
  input wire ifb_phase_t phaseIn,
  input wire logic [15:0] levelIn,
  input wire logic [6:0] holdIn,
  output ifb_phase_t phaseOut,
  output logic [15:0] levelOut,
  output logic [6:0] holdOut,
  output logic [15:0] result,
  output logic error
);

  logic [15:0] startLvl;
  logic [15:0] chosen;
  logic [15:0] target;
  logic [15:0] upStep;
  logic [15:0] downStep;

  // one rate step toward a goal, landing on it rather than past it
  function automatic logic [15:0] moveToward(input logic [15:0] cur, input logic [15:0] goal,
                                             input logic [15:0] amount);
    logic signed [17:0] nxt;
    nxt = 18'sd0;
    if (signed'(cur) < signed'(goal)) begin
      nxt = 18'(signed'(cur)) + 18'({1'b0, amount[14:0]});
      return (nxt > 18'(signed'(goal))) ? goal : nxt[15:0];
    end
    nxt = 18'(signed'(cur)) - 18'({1'b0, amount[14:0]});
    return (nxt < 18'(signed'(goal))) ? goal : nxt[15:0];
  endfunction : moveToward

  assign startLvl = ifb_sat16(48'(signed'(rampBaseLevel)) + 48'(signed'(offset)));
  assign chosen = levelChoice ? level2 : level1;
  assign target = (signed'(chosen) > signed'(ceilingLevel)) ? ceilingLevel : chosen;
  assign upStep = moveToward(levelIn, target, rate);
  assign downStep = moveToward(levelIn, startLvl, rate);

  // ==========================================================================
  // phase sequence; the ms step only paces movement and hold counts
  always_comb begin
    phaseOut = phaseIn;
    levelOut = levelIn;
    holdOut = holdIn;
    if (!enable) begin
      phaseOut = R_IDLE;
      levelOut = startLvl;
      holdOut = 7'h00;
    end else begin
      case (phaseIn)
        R_IDLE: begin
          phaseOut = R_HOLD;
          levelOut = startLvl;
          holdOut = 7'h00;
        end
        R_HOLD: begin
          levelOut = startLvl;
          if (step) begin
            holdOut = holdIn + 7'h01;
            if (holdIn == HOLD_TICKS - 7'h01) begin
              phaseOut = R_RUN;
              holdOut = 7'h00;
            end
          end
        end
        R_RUN: begin
          if (step) begin
            levelOut = upStep;
          end
        end
        R_DOWN: begin
          if (step) begin
            levelOut = downStep;
            if (downStep == startLvl) begin
              phaseOut = R_LAST;
              holdOut = 7'h00;
            end
          end
        end
        R_LAST: begin
          if (step) begin
            holdOut = holdIn + 7'h01;
            if (holdIn == HOLD_TICKS - 7'h01) begin
              phaseOut = R_DONE;
              levelOut = offset;
            end
          end
        end
        R_DONE: levelOut = offset;
        default: begin
          phaseOut = R_IDLE;
          levelOut = startLvl;
          holdOut = 7'h00;
        end
      endcase
      // a rising halt request preempts holding or running
      if (haltReq && !haltPrev && (phaseIn == R_HOLD || phaseIn == R_RUN)) begin
        phaseOut = R_DOWN;
        levelOut = levelIn;
      end
    end
  end

  // result scaling; a zero divisor flags the coil and leaves result at zero
  assign error = (scale == 16'h0000);
  assign result = error ? 16'h0000 :
      ifb_sat16((48'(signed'(levelIn)) - 48'(signed'(offset))) / 48'(signed'(scale)));

endmodule : ifb_ramp

`default_nettype wire

// ### dv/ifb_user_prog.sv
// apb master standing in for the user program
`default_nettype none
module ifb_user_prog (
  input wire logic clock,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic psel = 1'b0,
  output logic penable = 1'b0,
  output logic pwrite = 1'b0,
  output logic [15:0] paddr = 16'h0000,
  output logic [31:0] pwdata = 32'h00000000
);
  timeunit 1ns;
  timeprecision 1ps;
  // request held until pready is seen high at an edge; bounded so a hang is caught
  task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d,
    output logic [31:0] rd, output logic err, output logic ok);
    ok = 1'b0;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    for (int n = 0; n < 16 && !ok; n++) begin
      @(posedge clock);
      ok = pready === 1'b1;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : ifb_user_prog
`default_nettype wire

// ### dv/integer_function_blocks_test.sv
// self-checking bench for the integer function units
`default_nettype none
module integer_function_blocks_test
  import ifb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MSC = 200; // short tick keeps the 100-tick holds affordable
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, err;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [NUM_UNITS-1:0] errorCoil;
  int failures = 0;
  int comparisons = 0;

  initial forever #12.5 clock = ~clock;

  ifb_core #(.MS_CYCLES_P(MSC)) uut (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .errorCoil(errorCoil));
  ifb_user_prog prog (.clock(clock), .prdata(prdata), .pready(pready), .pslverr(pslverr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

  task automatic summarize();
    if (failures == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("FAIL at %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d);
    logic ok;
    prog.xfer(w, a, d, rd, err, ok);
    if (!ok) begin
      failures++;
      summarize();
    end
  endtask : acc

  task automatic par(input int n, input int s, input logic [31:0] d);
    acc(1'b1, 16'((n * 8 + s) * 4), d);
  endtask : par

  // two full scans after a control write also cover one chained reference
  task automatic ctl(input int n, input logic [4:0] c);
    acc(1'b1, 16'h1000 + 16'(n * 4), {27'h0000000, c});
    repeat (230) @(posedge clock);
  endtask : ctl

  task automatic st(input int n, input logic [16:0] exp, input logic [16:0] m);
    acc(1'b0, 16'h2000 + 16'(n * 4), 32'h00000000);
    check(rd & {15'h0000, m}, {15'h0000, exp & m});
  endtask : st

  initial begin
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    acc(1'b0, 16'h3000, 32'h00000000);
    check({31'h00000000, err}, 32'h00000001);
    // add-subtract: overflow with and without target, disabled, then a plain sum
    par(0, 0, 32'h00007FFF);
    par(0, 1, 32'h00000001);
    ctl(0, 5'h03);
    st(0, 17'h10000, 17'h10000);
    check({31'h00000000, errorCoil[0]}, 32'h00000001);
    ctl(0, 5'h01);
    st(0, 17'h00000, 17'h10000);
    ctl(0, 5'h02);
    st(0, 17'h00000, 17'h10000);
    par(0, 0, 32'h00000064);
    par(0, 1, 32'h00000032);
    par(0, 2, 32'h0000001E);
    ctl(0, 5'h03);
    st(0, 17'h00078, 17'h1FFFF);
    // multiply-divide fed by the add-subtract result, then a zero divisor
    par(31, 0, 32'h00010000);
    par(31, 1, 32'h0000FFFC);
    par(31, 2, 32'h00000006);
    ctl(31, 5'h03);
    st(31, 17'h0FFB0, 17'h1FFFF);
    par(31, 2, 32'h00000000);
    ctl(31, 5'h03);
    st(31, 17'h10000, 17'h10000);
    // selector: every select code, then disabled
    for (int s = 0; s < 4; s++) begin
      par(77, s, 32'h00000011 * (s + 1));
    end
    for (int s = 0; s < 4; s++) begin
      ctl(77, {1'b0, s[0], s[1], 1'b1, 1'b1});
      st(77, 17'(32'h00000011 * (s + 1)), 17'h1FFFF);
    end
    ctl(77, 5'h02);
    st(77, 17'h00000, 17'h1FFFF);
    // pid: zero sample period, then zero gain
    par(62, 3, 32'h00000005);
    ctl(62, 5'h03);
    st(62, 17'h10000, 17'h10000);
    par(62, 2, 32'h00000001);
    par(62, 3, 32'h00000000);
    ctl(62, 5'h03);
    st(62, 17'h10000, 17'h10000);
    // ramp: zero divisor, hold, clamped climb, halt
    ctl(92, 5'h03);
    st(92, 17'h10000, 17'h10000);
    ctl(92, 5'h00);
    par(92, 0, 32'h00000020);
    par(92, 2, 32'h00000010);
    par(92, 3, 32'h0000000A);
    par(92, 4, 32'h00000004);
    par(92, 5, 32'h00000001);
    par(92, 6, 32'h00000002);
    ctl(92, 5'h03);
    st(92, 17'h00005, 17'h1FFFF);
    repeat (22000) @(posedge clock);
    st(92, 17'h00006, 17'h1FFFF);
    // second level below the start level: the ramp walks down to it
    par(92, 1, 32'h00000008);
    ctl(92, 5'h07);
    repeat (2000) @(posedge clock);
    st(92, 17'h00002, 17'h1FFFF);
    ctl(92, 5'h17);
    repeat (22000) @(posedge clock);
    st(92, 17'h00000, 17'h1FFFF);
    summarize();
  end
endmodule : integer_function_blocks_test
`default_nettype wire
